// ### logic/node_status_defines.svh
`ifndef NODE_STATUS_DEFINES_SVH
`define NODE_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define NS_OFS_CTRL      8'h00
`define NS_OFS_STATUS    8'h04
`define NS_OFS_IRQ_STAT  8'h08
`define NS_OFS_IRQ_MASK  8'h0C

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define NS_CTRL_NMT_LSB  0
`define NS_CTRL_NMT_MSB  1
`define NS_CTRL_CFG_BIT  2
`define NS_CTRL_LOST_BIT 3
`define NS_CTRL_RESET    4'h0

// ----------------------------------------------------------------------
// interrupt bits: warning reached, bus-off entered, link to cpu lost
// ----------------------------------------------------------------------
`define NS_IRQ_WARN_BIT  0
`define NS_IRQ_BOFF_BIT  1
`define NS_IRQ_LOST_BIT  2
`define NS_IRQ_RESET     3'h0

// ----------------------------------------------------------------------
// bit rates in kHz and indicator timing
// ----------------------------------------------------------------------
`define NS_RATE_1000     11'h3E8
`define NS_RATE_800      11'h320
`define NS_RATE_500      11'h1F4
`define NS_RATE_250      11'h0FA
`define NS_CLK_MHZ       125
`define NS_BLINK_MS      200
`define NS_BLINK_CYCLES  (`NS_BLINK_MS * 1000 * `NS_CLK_MHZ)
`define NS_SINGLE_PHASES 6
`define NS_DOUBLE_PHASES 8

`endif

// ### logic/node_status_pkg.sv
// ----------------------------------------------------------------------
// shared types
// ----------------------------------------------------------------------
package node_status_pkg;

    // network management state as written by software
    typedef enum logic [1:0] {
        NMT_PREOP,
        NMT_STOPPED,
        NMT_OPERATIONAL,
        NMT_INIT
    } nmt_state_type;

endpackage

// ### logic/canopen_node_status_config.sv
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "node_status_defines.svh"

// What this block does
// - green indicator blinks intermittently while state is pre-operational
// - green indicator single-flashes while state is stopped
// - green indicator is steadily lit while state is operational
// - red indicator dark when ready, intermittent during configuration stage
// - red indicator single-flashes when an error counter reached warning level
// - red indicator double-flashes when communication with the cpu is lost
// - red indicator steadily lit while controller is bus-off
// - low four address bits come from the sixteen-position rotary switch
// - extension switch gives address bit four, selecting 0-15 or 16-31
// - address switches are taken only at reset
// - address also sets bus priority, lower address means higher priority
// - two rate switches select 1000, 800, 500 or 250 kHz
// - rate switches are taken only at reset
module canopen_node_status_config #(
    parameter int unsigned BLINK_CYCLES = `NS_BLINK_CYCLES
) (
    // clock, reset, enable
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // avalon-mm slave
    input  wire logic [7:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [3:0]  byteenable_in,
    input  wire logic [31:0] writedata_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    // switches
    input  wire logic [3:0]  addr_rotary_in,
    input  wire logic        addr_msb_in,
    input  wire logic [1:0]  bitrate_select_in,
    // can controller status
    input  wire logic        can_err_warn_in,
    input  wire logic        can_bus_off_in,
    // results
    output logic [4:0]       node_addr_out,
    output logic [4:0]       node_priority_out,
    output logic [10:0]      bitrate_khz_out,
    output logic             settings_valid_out,
    output logic             led_run_out,
    output logic             led_err_out,
    output logic             irq_out
);

    localparam int unsigned TICK_W = $clog2(BLINK_CYCLES);

    // ------------------------------------------------------------------
    // switch capture
    // ------------------------------------------------------------------
    logic [4:0]  node_addr_r;
    logic [10:0] rate_r;
    logic        captured_r;
    logic [10:0] rate_nxt;

    // bit 0 is the first rate switch, bit 1 the second
    always_comb
    begin
        unique case (bitrate_select_in)
            2'b11:   rate_nxt = `NS_RATE_1000;
            2'b10:   rate_nxt = `NS_RATE_800;
            2'b01:   rate_nxt = `NS_RATE_500;
            default: rate_nxt = `NS_RATE_250;
        endcase
    end

    // taken once on the first enabled edge after reset release; a flop under
    // async reset may only load a constant, so switches wait for this edge
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            node_addr_r <= 5'h00;
            rate_r      <= `NS_RATE_250;
            captured_r  <= 1'b0;
        end
        else if (ce_in && !captured_r)
        begin
            node_addr_r <= {addr_msb_in, addr_rotary_in};
            rate_r      <= rate_nxt;
            captured_r  <= 1'b1;
        end
    end

    assign node_addr_out      = node_addr_r;
    assign node_priority_out  = 5'h1F - node_addr_r; // larger value wins
    assign bitrate_khz_out    = rate_r;
    assign settings_valid_out = captured_r;

    // ------------------------------------------------------------------
    // blink timebase
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_r;
    logic              tick;
    logic              blink_r;
    logic [2:0]        single_ph_r;
    logic [2:0]        double_ph_r;

    assign tick = (tick_cnt_r == TICK_W'(BLINK_CYCLES - 1));

    // one tick every 200 ms
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tick_cnt_r <= '0;
        else if (ce_in)
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end

    // phases: intermittent toggles each tick, flashes light phase 0 (and 2)
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            blink_r     <= 1'b0;
            single_ph_r <= 3'h0;
            double_ph_r <= 3'h0;
        end
        else if (ce_in && tick)
        begin
            blink_r     <= !blink_r;
            single_ph_r <= (single_ph_r == 3'(`NS_SINGLE_PHASES - 1)) ? 3'h0
                                                                      : single_ph_r + 3'h1;
            double_ph_r <= double_ph_r + 3'h1; // wraps at eight phases
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [3:0] ctrl_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic       ack_r;
    logic [31:0] rdata_r;
    logic       wr_go;
    logic [2:0] irq_evt;
    logic [2:0] irq_clr;
    logic       warn_d_r;
    logic       boff_d_r;
    logic       lost_d_r;
    logic [31:0] rd_mux;
    node_status_pkg::nmt_state_type nmt;

    assign nmt   = node_status_pkg::nmt_state_type'(ctrl_r[`NS_CTRL_NMT_MSB:`NS_CTRL_NMT_LSB]);
    assign wr_go = write_in && ack_r && ce_in && byteenable_in[0];

    // one wait cycle on every access: data is prepared while waiting
    assign waitrequest_out = (read_in || write_in) && !ack_r;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ack_r <= 1'b0;
        else if (ce_in)
            ack_r <= (read_in || write_in) && !ack_r;
    end

    // unmapped offsets read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (address_in)
            `NS_OFS_CTRL:     rd_mux = {28'h0, ctrl_r};
            `NS_OFS_STATUS:   rd_mux = {20'h0_0000, led_err_out, led_run_out, can_bus_off_in,
                                        can_err_warn_in, captured_r, rate_nxt == rate_r,
                                        node_addr_r, captured_r};
            `NS_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
            `NS_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_r <= 32'h0000_0000;
        else if (ce_in && read_in && !ack_r)
            rdata_r <= rd_mux;
    end

    assign readdata_out = rdata_r;

    // software sets state, configuration stage and lost-link flag
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ctrl_r <= `NS_CTRL_RESET;
        else if (wr_go && address_in == `NS_OFS_CTRL)
            ctrl_r <= writedata_in[3:0];
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_mask_r <= `NS_IRQ_RESET;
        else if (wr_go && address_in == `NS_OFS_IRQ_MASK)
            irq_mask_r <= writedata_in[2:0];
    end

    // edge detect of the fault conditions
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            warn_d_r <= 1'b0;
            boff_d_r <= 1'b0;
            lost_d_r <= 1'b0;
        end
        else if (ce_in)
        begin
            warn_d_r <= can_err_warn_in;
            boff_d_r <= can_bus_off_in;
            lost_d_r <= ctrl_r[`NS_CTRL_LOST_BIT];
        end
    end

    assign irq_evt[`NS_IRQ_WARN_BIT] = can_err_warn_in && !warn_d_r;
    assign irq_evt[`NS_IRQ_BOFF_BIT] = can_bus_off_in && !boff_d_r;
    assign irq_evt[`NS_IRQ_LOST_BIT] = ctrl_r[`NS_CTRL_LOST_BIT] && !lost_d_r;
    assign irq_clr = (wr_go && address_in == `NS_OFS_IRQ_STAT) ? writedata_in[2:0] : 3'h0;

    // write one to clear; a new event in the same cycle wins over the clear
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_stat_r <= `NS_IRQ_RESET;
        else if (ce_in)
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------------
    logic run_nxt;
    logic err_nxt;
    logic single_on;
    logic double_on;
    logic run_r;
    logic err_r;

    assign single_on = (single_ph_r == 3'h0);
    assign double_on = (double_ph_r == 3'h0) || (double_ph_r == 3'h2);

    always_comb
    begin
        unique case (nmt)
            node_status_pkg::NMT_PREOP:       run_nxt = blink_r;
            node_status_pkg::NMT_STOPPED:     run_nxt = single_on;
            node_status_pkg::NMT_OPERATIONAL: run_nxt = 1'b1;
            node_status_pkg::NMT_INIT:        run_nxt = 1'b0;
        endcase
    end

    // worst condition shown: bus-off, lost link, warning, configuring
    always_comb
    begin
        if (can_bus_off_in)
            err_nxt = 1'b1;
        else if (ctrl_r[`NS_CTRL_LOST_BIT])
            err_nxt = double_on;
        else if (can_err_warn_in)
            err_nxt = single_on;
        else if (ctrl_r[`NS_CTRL_CFG_BIT])
            err_nxt = blink_r;
        else
            err_nxt = 1'b0;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            run_r <= 1'b0;
            err_r <= 1'b0;
        end
        else if (ce_in)
        begin
            run_r <= run_nxt;
            err_r <= err_nxt;
        end
    end

    assign led_run_out = run_r;
    assign led_err_out = err_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    green_preop_a: assert property (ce_in && nmt == node_status_pkg::NMT_PREOP
        |=> led_run_out == $past(blink_r))
        else $error("green not intermittent in pre-operational");
    green_stop_a: assert property (ce_in && nmt == node_status_pkg::NMT_STOPPED
        |=> led_run_out == ($past(single_ph_r) == 3'h0))
        else $error("green not single flash in stopped");
    green_oper_a: assert property (ce_in && nmt == node_status_pkg::NMT_OPERATIONAL
        |=> led_run_out)
        else $error("green not lit in operational");
    red_idle_a: assert property (ce_in && !can_bus_off_in && !can_err_warn_in
        && ctrl_r[3:2] == 2'b00 |=> !led_err_out)
        else $error("red lit while ready");
    red_warn_a: assert property (ce_in && can_err_warn_in && !can_bus_off_in
        && !ctrl_r[`NS_CTRL_LOST_BIT] |=> led_err_out == ($past(single_ph_r) == 3'h0))
        else $error("red not single flash on warning");
    red_lost_a: assert property (ce_in && !can_bus_off_in && ctrl_r[`NS_CTRL_LOST_BIT]
        |=> led_err_out == ($past(double_ph_r) inside {3'h0, 3'h2}))
        else $error("red not double flash on lost link");
    red_boff_a: assert property (ce_in && can_bus_off_in |=> led_err_out)
        else $error("red not lit in bus-off");
    addr_take_a: assert property ($rose(captured_r)
        |-> node_addr_out == $past({addr_msb_in, addr_rotary_in}))
        else $error("address not taken from switches");
    addr_hold_a: assert property (captured_r |=> $stable(node_addr_r) && $stable(rate_r))
        else $error("settings changed after capture");
    prio_order_a: assert property (node_priority_out + node_addr_out == 5'h1F)
        else $error("priority not tied to address");
    rate_fast_a: assert property ($rose(captured_r) && $past(bitrate_select_in) == 2'b10
        |-> bitrate_khz_out == `NS_RATE_800)
        else $error("800 kHz not selected");
    blink_step_a: assert property ($changed(blink_r) |-> $past(tick && ce_in))
        else $error("blink moved off the tick");
    irq_keep_a: assert property (ce_in && irq_evt[0] |=> irq_stat_r[0])
        else $error("event lost against clear");

    boff_seen_c: cover property (ce_in && can_bus_off_in ##1 led_err_out);
    lost_flash_c: cover property (ctrl_r[`NS_CTRL_LOST_BIT] && $rose(led_err_out));
    irq_fire_c: cover property ($rose(irq_out));
    rd_done_c: cover property (read_in && !waitrequest_out);

endmodule

`default_nettype wire

// ### tb/can_status_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// far side: bus traffic as seen by the node's can controller
// ----------------------------------------------------------------------
module can_status_model #(
    parameter logic [10:0] BUS_RATE_KHZ = 11'h0FA,
    parameter logic [4:0]  MASTER_ADDR  = 5'h00
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // node settings and bench commands
    input  wire logic [10:0] bitrate_khz_in,
    input  wire logic [4:0]  node_addr_in,
    input  wire logic        valid_in,
    input  wire logic        warn_cmd_in,
    input  wire logic        boff_cmd_in,
    // controller status levels
    output logic             warn_out,
    output logic             boff_out
);
    logic clash;

    // a node off the shared rate or on the master's address sees bus errors
    assign clash = valid_in && ((bitrate_khz_in != BUS_RATE_KHZ)
                   || (node_addr_in == MASTER_ADDR));

    // levels change only on the clock, like a real controller
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            warn_out <= 1'b0;
            boff_out <= 1'b0;
        end
        else
        begin
            warn_out <= warn_cmd_in | clash;
            boff_out <= boff_cmd_in;
        end
    end
endmodule

`default_nettype wire

// ### tb/canopen_node_status_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "node_status_defines.svh"

// compare and count; mismatch printed at once
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("Error at %0t got %0h expected %0h", $time, (got), (exp)); \
        end \
    end

module canopen_node_status_config_tb;
    localparam int unsigned BLINK = 8;
    logic        clk_sys_in, rst_n_in, ce_in, read_in, write_in, addr_msb_in;
    logic        can_err_warn, can_bus_off, warn_cmd, boff_cmd, settings_valid_out;
    logic        waitrequest_out, led_run_out, led_err_out, irq_out;
    logic [7:0]  address_in;
    logic [3:0]  byteenable_in, addr_rotary_in;
    logic [1:0]  bitrate_select_in, r;
    logic [31:0] writedata_in, readdata_out, rd, seed;
    logic [4:0]  node_addr_out, node_priority_out, a;
    logic [10:0] bitrate_khz_out;
    int          n_errors, samples_checked, cycles;
    int          run_exp[4] = '{48, 16, 96, 0};

    // ------------------------------------------------------------------
    // design and far-side model
    // ------------------------------------------------------------------
    canopen_node_status_config #(.BLINK_CYCLES(BLINK)) u_canopen_node_status_config (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in),
        .byteenable_in(byteenable_in), .writedata_in(writedata_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .addr_rotary_in(addr_rotary_in), .addr_msb_in(addr_msb_in),
        .bitrate_select_in(bitrate_select_in), .can_err_warn_in(can_err_warn),
        .can_bus_off_in(can_bus_off), .node_addr_out(node_addr_out),
        .node_priority_out(node_priority_out), .bitrate_khz_out(bitrate_khz_out),
        .settings_valid_out(settings_valid_out), .led_run_out(led_run_out),
        .led_err_out(led_err_out), .irq_out(irq_out));

    can_status_model u_can_status_model (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bitrate_khz_in(bitrate_khz_out),
        .node_addr_in(node_addr_out), .valid_in(settings_valid_out),
        .warn_cmd_in(warn_cmd), .boff_cmd_in(boff_cmd),
        .warn_out(can_err_warn), .boff_out(can_bus_off));

    // ------------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // the whole run needs about 1150 cycles; a hang stops well beyond
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [10:0] rate_exp(input logic [1:0] sel);
        case (sel)
            2'h3: return `NS_RATE_1000;
            2'h2: return `NS_RATE_800;
            2'h1: return `NS_RATE_500;
            default: return `NS_RATE_250;
        endcase
    endfunction

    // one avalon access; waits for the slave, only the bench timeout ends a hang
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                       input logic [3:0] be);
        address_in <= ad;
        writedata_in <= d;
        byteenable_in <= be;
        write_in <= wr;
        read_in <= ~wr;
        @(posedge clk_sys_in);
        while (waitrequest_out !== 1'b0)
            @(posedge clk_sys_in);
        rd = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic do_reset(input logic [4:0] ad, input logic [1:0] rs);
        addr_rotary_in <= ad[3:0];
        addr_msb_in <= ad[4];
        bitrate_select_in <= rs;
        rst_n_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
    endtask

    // lit cycles over whole pattern periods do not depend on phase
    task automatic count_lit(input logic red, input int n, input int exp);
        int c;
        c = 0;
        repeat (3) @(posedge clk_sys_in);
        repeat (n)
        begin
            @(posedge clk_sys_in);
            c += red ? (led_err_out === 1'b1) : (led_run_out === 1'b1);
        end
        `CHK(c, exp)
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_n_in = 1'b0;
        ce_in = 1'b1;
        read_in = 1'b0;
        write_in = 1'b0;
        address_in = 8'h00;
        byteenable_in = 4'hF;
        writedata_in = 32'h0;
        addr_rotary_in = 4'h0;
        addr_msb_in = 1'b0;
        bitrate_select_in = 2'h0;
        warn_cmd = 1'b0;
        boff_cmd = 1'b0;
        seed = 32'h0001_329B;
        // corner and random switch settings, all four rate codes
        for (int i = 0; i < 8; i++)
        begin
            seed = xorshift(seed);
            a = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : seed[4:0];
            r = i[1:0];
            do_reset(a, r);
            `CHK(settings_valid_out, 1'b1)
            `CHK(node_addr_out, a)
            `CHK(node_priority_out, 5'h1F - a)
            `CHK(bitrate_khz_out, rate_exp(r))
            addr_rotary_in <= ~a[3:0];
            addr_msb_in <= ~a[4];
            bitrate_select_in <= ~r;
            repeat (4) @(posedge clk_sys_in);
            `CHK(node_addr_out, a)
            `CHK(bitrate_khz_out, rate_exp(r))
        end
        do_reset(5'h05, 2'h0);
        // clock enable low must freeze the blink for longer than one tick
        ce_in <= 1'b0;
        @(posedge clk_sys_in);
        rd[0] = led_run_out;
        repeat (8)
        begin
            @(posedge clk_sys_in);
            `CHK(led_run_out, rd[0])
        end
        ce_in <= 1'b1;
        // register file: reset value, refused writes, unmapped place
        bus(1'b0, `NS_OFS_CTRL, 32'h0, 4'hF);
        `CHK(rd, 32'h0)
        bus(1'b1, `NS_OFS_CTRL, 32'h2, 4'h0);
        bus(1'b0, `NS_OFS_CTRL, 32'h0, 4'hF);
        `CHK(rd, 32'h0)
        bus(1'b1, 8'h10, 32'hFF, 4'hF);
        bus(1'b0, 8'h10, 32'h0, 4'hF);
        `CHK(rd, 32'h0)
        bus(1'b0, `NS_OFS_STATUS, 32'h0, 4'hF);
        `CHK(rd[5:0], 6'h0B)
        `CHK(rd[9:6], 4'h3)
        // green indicator for each management state
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, `NS_OFS_CTRL, s, 4'hF);
            bus(1'b0, `NS_OFS_CTRL, 32'h0, 4'hF);
            `CHK(rd, s)
            count_lit(1'b0, 96, run_exp[s]);
        end
        // red indicator, each cause stacked over the lower ones
        count_lit(1'b1, 96, 0);
        bus(1'b1, `NS_OFS_CTRL, 32'h4, 4'hF);
        count_lit(1'b1, 96, 48);
        warn_cmd <= 1'b1;
        count_lit(1'b1, 96, 16);
        bus(1'b1, `NS_OFS_CTRL, 32'hC, 4'hF);
        count_lit(1'b1, 128, 32);
        boff_cmd <= 1'b1;
        count_lit(1'b1, 96, 96);
        // interrupts: all three events latched, bus-off alone unmasked, then cleared
        `CHK(irq_out, 1'b0)
        bus(1'b0, `NS_OFS_IRQ_STAT, 32'h0, 4'hF);
        `CHK(rd[2:0], 3'h7)
        bus(1'b1, `NS_OFS_IRQ_MASK, 32'h2, 4'hF);
        `CHK(irq_out, 1'b1)
        bus(1'b1, `NS_OFS_IRQ_STAT, 32'h2, 4'hF);
        `CHK(irq_out, 1'b0)
        bus(1'b0, `NS_OFS_IRQ_STAT, 32'h0, 4'hF);
        `CHK(rd[2:0], 3'h5)
        finish_test();
    end
endmodule

`default_nettype wire
